// >>> verilog/spi_cfg_pkg.sv
package spi_cfg_pkg;
  // ==========================================================
  // Widths
  localparam int ADDR_W  = 13;
  localparam int DATA_W  = 8;
  localparam int PIN_W   = 4;

  // ==========================================================
  // Register offsets
  localparam logic [12:0] ADDR_PORT_CFG  = 13'h0000;
  localparam logic [12:0] ADDR_CHAN_IDX  = 13'h0005;
  localparam logic [12:0] ADDR_LOCAL_LO  = 13'h0008;
  localparam logic [12:0] ADDR_LOCAL_HI  = 13'h0020;
  localparam logic [12:0] ADDR_SYNC_CTL  = 13'h003a;
  localparam logic [12:0] ADDR_STATUS    = 13'h003f;
  localparam logic [12:0] ADDR_SYNC_MODE = 13'h0059;
  localparam logic [12:0] ADDR_XFER      = 13'h00ff;

  // ==========================================================
  // Reset values and commands
  localparam logic [7:0] PORT_CFG_RST  = 8'h18;
  localparam logic [7:0] PORT_LSB_MASK = 8'h42;
  localparam logic [7:0] XFER_CMD      = 8'h01;
  localparam logic [1:0] CHAN_RST      = 2'h3;
  localparam logic [1:0] WL_STREAM     = 2'h3;
  localparam logic [3:0] PIN_RST       = 4'h2;

  // ==========================================================
  // Field positions
  localparam int PORT_LSB_HI   = 6;
  localparam int PORT_LSB_LO   = 1;
  localparam int CHAN_A_BIT    = 0;
  localparam int CHAN_B_BIT    = 1;
  localparam int SYNC_EN_BIT   = 1;
  localparam int SYNC_ONCE_BIT = 2;
  localparam int MODE_EDGE_BIT = 1;
  localparam int MODE_FALL_BIT = 0;
  localparam int INSTR_RW_BIT  = 15;
  localparam int PIN_SCLK      = 0;
  localparam int PIN_CSN       = 1;
  localparam int PIN_SDIO      = 2;
  localparam int PIN_SYNC      = 3;

  // ==========================================================
  // Serial frame states, Gray along idle-instr-data-done
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_INSTR = 2'h1,
    ST_DATA  = 2'h3,
    ST_DONE  = 2'h2
  } spi_state_t;
endpackage

// >>> verilog/pin_sync.sv
`timescale 1ns/100ps
module pin_sync (
  input  wire logic                            core_clk_i,
  input  wire logic                            sys_rst_i,
  input  wire logic [spi_cfg_pkg::PIN_W-1:0]   pin_i,
  output logic      [spi_cfg_pkg::PIN_W-1:0]   pin_o
);
  // ==========================================================
  // Two-flop synchroniser, first stage feeds only the second
  logic [spi_cfg_pkg::PIN_W-1:0] meta;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta  <= spi_cfg_pkg::PIN_RST;
      pin_o <= spi_cfg_pkg::PIN_RST;
    end else begin
      meta  <= pin_i;
      pin_o <= meta;
    end
  end
endmodule // pin_sync

// >>> verilog/spi_cfg_port.sv
`timescale 1ns/100ps
// Behaviour
// R1 - Sync control picks one-shot or every strobe
// R2 - Strobe retimed to sample clock first
// R3 - Host drives strobe synchronous to clock
// R4 - Mode bit picks level or edge detect
// R5 - Edge mode: bit picks rising or falling
// R6 - Select low enables, high ignores activity
// R7 - Frame starts at select fall, clock rise
// R8 - Select held low keeps streaming
// R9 - Select high between bytes stalls frame; a streaming frame returns to idle instead
// R10 - Select high releases pins, secondary functions; secondary enable stays low while a stalled frame waits
// R11 - Sixteen-bit instruction opens each frame
// R12 - Word-length bits set data length
// R13 - Data moves in whole bytes
// R14 - Instruction carries read/write direction
// R15 - Readback turns data pin to output
// R16 - Host drives clock, select; releases on read
// R17 - MSB first at reset, LSB selectable
// R18 - Valid strobe resets divider, once or always
// R19 - Shadowed registers apply on transfer command
// R20 - Channel bits steer local register access
// R21 - Instruction: direction, length, 13-bit address
// R22 - Address steps by one per byte
module spi_cfg_port (
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        sclk_i,
  input  wire logic        serial_select_n_i,
  input  wire logic        sdio_i,
  output logic             sdio_o,
  output logic             sdio_oe_o,
  input  wire logic        sync_i,
  input  wire logic [12:0] bus_addr_i,
  input  wire logic [7:0]  bus_wdata_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_rd_i,
  output logic      [7:0]  bus_rdata_o,
  output logic             div_resync_o,
  output logic             secondary_en_o
);
  // ==========================================================
  // Declarations
  logic [3:0]                pin_s;
  logic                      sclk_s;
  logic                      csn_s;
  logic                      sdio_s;
  logic                      sync_s;
  logic                      sclk_d;
  logic                      sync_d;
  logic                      rise;
  spi_cfg_pkg::spi_state_t   state;
  spi_cfg_pkg::spi_state_t   next_state;
  logic [3:0]                bit_cnt;
  logic [3:0]                next_bit_cnt;
  logic [15:0]               instr_sr;
  logic [15:0]               next_instr;
  logic [15:0]               instr_new;
  logic [7:0]                rx_sr;
  logic [7:0]                next_rx;
  logic [7:0]                rx_new;
  logic [7:0]                tx_sr;
  logic [7:0]                next_tx;
  logic [12:0]               addr;
  logic [12:0]               next_addr;
  logic                      rw;
  logic                      next_rw;
  logic [1:0]                bytes_left;
  logic [1:0]                next_bytes;
  logic                      stream;
  logic                      next_stream;
  logic                      spi_pend;
  logic                      next_pend;
  logic [12:0]               pend_addr;
  logic [12:0]               next_pend_addr;
  logic [7:0]                pend_data;
  logic [7:0]                next_pend_data;
  logic                      next_sdo;
  logic                      next_oe;
  logic                      next_sec;
  logic [7:0]                next_rdata;
  logic                      lsb_first;
  logic                      next_lsb;
  logic [1:0]                chan_sel;
  logic [1:0]                next_chan;
  logic                      wr_go;
  logic [12:0]               wa;
  logic [7:0]                wd;
  logic                      xfer_go;
  logic [7:0]                act_ctl;
  logic [7:0]                next_act_ctl;
  logic [7:0]                act_mode;
  logic [7:0]                next_act_mode;
  logic                      armed;
  logic                      next_armed;
  logic                      sync_evt;
  logic                      sync_valid;
  logic [7:0]                shadow_a [0:255];
  logic [7:0]                shadow_b [0:255];

  // ==========================================================
  // Pin retiming
  pin_sync u_pin_sync (                                    // [R2]
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .pin_i      ({sync_i, sdio_i, serial_select_n_i, sclk_i}),
    .pin_o      (pin_s)
  );

  assign sclk_s = pin_s[spi_cfg_pkg::PIN_SCLK];
  assign csn_s  = pin_s[spi_cfg_pkg::PIN_CSN];
  assign sdio_s = pin_s[spi_cfg_pkg::PIN_SDIO];
  assign sync_s = pin_s[spi_cfg_pkg::PIN_SYNC];
  assign rise   = sclk_s & ~sclk_d;

  // ==========================================================
  // Register decode
  function automatic logic is_local(input logic [12:0] a);
    return (a >= spi_cfg_pkg::ADDR_LOCAL_LO) && (a <= spi_cfg_pkg::ADDR_LOCAL_HI);
  endfunction

  // Both channels selected reads channel A
  function automatic logic [7:0] read_byte(input logic [12:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a[12:8] != 5'h00) begin
      v = 8'h00;
    end else if (a == spi_cfg_pkg::ADDR_PORT_CFG) begin
      v = spi_cfg_pkg::PORT_CFG_RST | (lsb_first ? spi_cfg_pkg::PORT_LSB_MASK : 8'h00);
    end else if (a == spi_cfg_pkg::ADDR_CHAN_IDX) begin
      v = {6'h00, chan_sel};
    end else if (a == spi_cfg_pkg::ADDR_STATUS) begin
      v = {4'h0, armed, sync_s, state};
    end else if (a == spi_cfg_pkg::ADDR_XFER) begin
      v = 8'h00;
    end else if (is_local(a) && !chan_sel[spi_cfg_pkg::CHAN_A_BIT]
                 && chan_sel[spi_cfg_pkg::CHAN_B_BIT]) begin      // [R20]
      v = shadow_b[a[7:0]];
    end else begin
      v = shadow_a[a[7:0]];
    end
    return v;
  endfunction

  // ==========================================================
  // Serial frame engine
  always_comb begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_instr     = instr_sr;
    next_rx        = rx_sr;
    next_tx        = tx_sr;
    next_addr      = addr;
    next_rw        = rw;
    next_bytes     = bytes_left;
    next_stream    = stream;
    next_pend      = spi_pend & bus_wr_i;
    next_pend_addr = pend_addr;
    next_pend_data = pend_data;
    // Bit order applies to instruction and data alike
    instr_new = lsb_first ? {sdio_s, instr_sr[15:1]} : {instr_sr[14:0], sdio_s}; // [R17]
    rx_new    = lsb_first ? {sdio_s, rx_sr[7:1]} : {rx_sr[6:0], sdio_s};          // [R17]
    if (csn_s) begin                                                 // [R6]
      // Stall only on a byte boundary of the instruction or of a fixed frame's data; a stream cannot
      // tell a stall from its end, so select high closes it
      if (state == spi_cfg_pkg::ST_DONE || bit_cnt[2:0] != 3'h0
          || (state == spi_cfg_pkg::ST_DATA && stream)                   // [R8]
          || (state == spi_cfg_pkg::ST_INSTR && bit_cnt == 4'h0)) begin // [R9]
        next_state   = spi_cfg_pkg::ST_IDLE;
        next_bit_cnt = 4'h0;
      end
    end else begin
      case (state)
        spi_cfg_pkg::ST_IDLE: begin
          next_state   = spi_cfg_pkg::ST_INSTR;                      // [R7]
          next_bit_cnt = 4'h0;
        end
        spi_cfg_pkg::ST_INSTR: begin
          if (rise) begin
            next_instr   = instr_new;
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == 4'hf) begin                               // [R11]
              next_state   = spi_cfg_pkg::ST_DATA;
              next_bit_cnt = 4'h0;
              next_rw      = instr_new[spi_cfg_pkg::INSTR_RW_BIT];   // [R14] [R21]
              next_bytes   = instr_new[14:13];                       // [R12] [R21]
              next_stream  = instr_new[14:13] == spi_cfg_pkg::WL_STREAM;
              next_addr    = instr_new[12:0];                        // [R21]
              next_tx      = read_byte(instr_new[12:0]);             // [R15]
            end
          end
        end
        spi_cfg_pkg::ST_DATA: begin
          if (rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
            next_rx      = rx_new;
            next_tx      = lsb_first ? {1'b0, tx_sr[7:1]} : {tx_sr[6:0], 1'b0};
            if (bit_cnt == 4'h7) begin                               // [R13]
              next_bit_cnt = 4'h0;
              next_addr    = addr + 13'h0001;                        // [R22]
              if (!rw) begin
                next_pend      = 1'b1;
                next_pend_addr = addr;
                next_pend_data = rx_new;
              end
              if (!stream && bytes_left == 2'h0) begin               // [R12]
                next_state = spi_cfg_pkg::ST_DONE;
              end else begin
                // Streaming never ends while select stays low
                next_bytes = stream ? bytes_left : bytes_left - 2'h1; // [R8]
                next_tx    = read_byte(addr + 13'h0001);
              end
            end
          end
        end
        spi_cfg_pkg::ST_DONE: begin
          next_state = spi_cfg_pkg::ST_DONE;
        end
        default: begin
          next_state = spi_cfg_pkg::ST_IDLE;
        end
      endcase
    end
    next_sdo = lsb_first ? next_tx[0] : next_tx[7];
    // Driver released whenever select is high
    next_oe  = ~csn_s & (next_state == spi_cfg_pkg::ST_DATA) & next_rw;  // [R15] [R10]
    next_sec = csn_s & (state == spi_cfg_pkg::ST_IDLE);                  // [R10]
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state          <= spi_cfg_pkg::ST_IDLE;
      bit_cnt        <= 4'h0;
      instr_sr       <= 16'h0000;
      rx_sr          <= 8'h00;
      tx_sr          <= 8'h00;
      addr           <= 13'h0000;
      rw             <= 1'b0;
      bytes_left     <= 2'h0;
      stream         <= 1'b0;
      spi_pend       <= 1'b0;
      pend_addr      <= 13'h0000;
      pend_data      <= 8'h00;
      sdio_o         <= 1'b0;
      sdio_oe_o      <= 1'b0;
      secondary_en_o <= 1'b0;
      sclk_d         <= 1'b0;
    end else begin
      state          <= next_state;
      bit_cnt        <= next_bit_cnt;
      instr_sr       <= next_instr;
      rx_sr          <= next_rx;
      tx_sr          <= next_tx;
      addr           <= next_addr;
      rw             <= next_rw;
      bytes_left     <= next_bytes;
      stream         <= next_stream;
      spi_pend       <= next_pend;
      pend_addr      <= next_pend_addr;
      pend_data      <= next_pend_data;
      sdio_o         <= next_sdo;
      sdio_oe_o      <= next_oe;
      secondary_en_o <= next_sec;
      sclk_d         <= sclk_s;
    end
  end

  // ==========================================================
  // Register file; local port wins, serial write waits a cycle
  always_comb begin
    wr_go     = bus_wr_i | spi_pend;
    wa        = bus_wr_i ? bus_addr_i : pend_addr;
    wd        = bus_wr_i ? bus_wdata_i : pend_data;
    xfer_go   = wr_go && wa == spi_cfg_pkg::ADDR_XFER && wd == spi_cfg_pkg::XFER_CMD; // [R19]
    next_lsb  = lsb_first;
    next_chan = chan_sel;
    if (wr_go && wa == spi_cfg_pkg::ADDR_PORT_CFG) begin
      next_lsb = wd[spi_cfg_pkg::PORT_LSB_HI] | wd[spi_cfg_pkg::PORT_LSB_LO];  // [R17]
    end
    if (wr_go && wa == spi_cfg_pkg::ADDR_CHAN_IDX) begin
      next_chan = wd[1:0];
    end
    next_rdata = bus_rd_i ? read_byte(bus_addr_i) : 8'h00;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 256; i++) begin
        shadow_a[i] <= 8'h00;
        shadow_b[i] <= 8'h00;
      end
    end else if (wr_go && wa[12:8] == 5'h00) begin
      if (is_local(wa)) begin                                          // [R20]
        if (chan_sel[spi_cfg_pkg::CHAN_A_BIT]) begin
          shadow_a[wa[7:0]] <= wd;
        end
        if (chan_sel[spi_cfg_pkg::CHAN_B_BIT]) begin
          shadow_b[wa[7:0]] <= wd;
        end
      end else begin
        shadow_a[wa[7:0]] <= wd;
      end
    end
  end

  // ==========================================================
  // Alignment strobe and divider resync
  always_comb begin
    if (act_mode[spi_cfg_pkg::MODE_EDGE_BIT]) begin                    // [R4]
      sync_evt = act_mode[spi_cfg_pkg::MODE_FALL_BIT] ? (~sync_s & sync_d)
                                                      : (sync_s & ~sync_d); // [R5]
    end else begin
      sync_evt = sync_s;                                               // [R4]
    end
    sync_valid = sync_evt & act_ctl[spi_cfg_pkg::SYNC_EN_BIT]
               & (~act_ctl[spi_cfg_pkg::SYNC_ONCE_BIT] | armed);       // [R1] [R18]
    // New transfer re-arms even if a strobe fires the same cycle
    if (xfer_go) begin
      next_armed = 1'b1;
    end else if (sync_valid & act_ctl[spi_cfg_pkg::SYNC_ONCE_BIT]) begin
      next_armed = 1'b0;                                               // [R18]
    end else begin
      next_armed = armed;
    end
    next_act_ctl  = xfer_go ? shadow_a[spi_cfg_pkg::ADDR_SYNC_CTL[7:0]] : act_ctl;   // [R19]
    next_act_mode = xfer_go ? shadow_a[spi_cfg_pkg::ADDR_SYNC_MODE[7:0]] : act_mode; // [R19]
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lsb_first    <= 1'b0;
      chan_sel     <= spi_cfg_pkg::CHAN_RST;
      bus_rdata_o  <= 8'h00;
      act_ctl      <= 8'h00;
      act_mode     <= 8'h00;
      armed        <= 1'b0;
      sync_d       <= 1'b0;
      div_resync_o <= 1'b0;
    end else begin
      lsb_first    <= next_lsb;
      chan_sel     <= next_chan;
      bus_rdata_o  <= next_rdata;
      act_ctl      <= next_act_ctl;
      act_mode     <= next_act_mode;
      armed        <= next_armed;
      sync_d       <= sync_s;
      div_resync_o <= sync_valid;                                      // [R18]
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  oe_release_a: assert property (csn_s |=> !sdio_oe_o) // [R10]
    else $error("data pin driven while select high");
  readback_turn_a: assert property ( // [R15]
    (state == spi_cfg_pkg::ST_INSTR && rise && bit_cnt == 4'hf && !csn_s
     && instr_new[spi_cfg_pkg::INSTR_RW_BIT]) |=> sdio_oe_o)
    else $error("readback did not turn data pin");
  instr_len_a: assert property ( // [R11]
    (state == spi_cfg_pkg::ST_INSTR && next_state == spi_cfg_pkg::ST_DATA)
    |-> bit_cnt == 4'hf)
    else $error("instruction not sixteen bits");
  addr_step_a: assert property ( // [R22]
    (state == spi_cfg_pkg::ST_DATA && rise && bit_cnt == 4'h7 && !csn_s)
    |=> addr == $past(addr) + 13'h0001)
    else $error("address did not step");
  stall_keep_a: assert property ( // [R9]
    (csn_s && state == spi_cfg_pkg::ST_DATA && bit_cnt == 4'h0 && !stream)
    |=> state == spi_cfg_pkg::ST_DATA && bit_cnt == 4'h0)
    else $error("stall lost the frame");
  xfer_apply_a: assert property ( // [R19]
    xfer_go |=> act_mode == $past(shadow_a[spi_cfg_pkg::ADDR_SYNC_MODE[7:0]])
                && act_ctl == $past(shadow_a[spi_cfg_pkg::ADDR_SYNC_CTL[7:0]]) && armed)
    else $error("transfer did not apply shadows");
  rise_resync_a: assert property ( // [R5]
    (act_mode[1:0] == 2'h2 && act_ctl[2:1] == 2'h1 && sync_s && !sync_d)
    |=> div_resync_o)
    else $error("rising edge missed");
  level_resync_a: assert property ( // [R4]
    (!act_mode[spi_cfg_pkg::MODE_EDGE_BIT] && act_ctl[2:1] == 2'h1 && sync_s)
    |=> div_resync_o)
    else $error("level strobe missed");
  one_shot_a: assert property ( // [R1]
    (div_resync_o && $past(act_ctl[spi_cfg_pkg::SYNC_ONCE_BIT]) && !$past(xfer_go))
    |-> !armed ##1 (!div_resync_o || $past(xfer_go)))
    else $error("one-shot fired twice");

  readback_c: cover property (sdio_oe_o ##1 rise);
  stream_c: cover property (stream && state == spi_cfg_pkg::ST_DATA && bit_cnt == 4'h7 && rise);
  stall_c: cover property (csn_s && state == spi_cfg_pkg::ST_DATA ##1 !csn_s);
  resync_c: cover property (div_resync_o);
endmodule // spi_cfg_port

// >>> sim/spi_host_model.sv
`timescale 1ns/100ps
// ==========================================================
// Serial master stand-in: drives clock, select and data pin
module spi_host_model (
  input  wire logic core_clk_i,
  input  wire logic sdio_i,
  output logic      sclk_o,
  output logic      select_n_o,
  output logic      sdio_o,
  output logic      sdio_oe_o
);
  initial begin
    sclk_o     = 1'b0;
    select_n_o = 1'b1;
    sdio_o     = 1'b0;
    sdio_oe_o  = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // Six core cycles per phase, above the four the port needs
  task automatic clock_bit(input logic b, input logic drive, input logic rel, output logic got);
    sdio_oe_o <= drive;
    sdio_o    <= b;
    wait_clk(6);
    got = sdio_i;
    sclk_o <= 1'b1;
    wait_clk(2);
    // Let go before the port turns the pin round
    if (rel) begin
      sdio_oe_o <= 1'b0;
      sdio_o    <= ~b;
    end
    wait_clk(4);
    sclk_o <= 1'b0;
  endtask

  task automatic shift(input logic [15:0] v, input int n, input logic lsb, input logic rd,
                       input logic rel_last, output logic [15:0] got);
    logic b;
    int   idx;
    got = '0;
    for (int i = 0; i < n; i++) begin
      idx = lsb ? i : n - 1 - i;
      clock_bit(v[idx], !rd, rel_last && (i == n - 1), b);
      got[idx] = b;
    end
  endtask

  task automatic frame_start();
    select_n_o <= 1'b0;
    wait_clk(6);
  endtask

  task automatic stall();
    select_n_o <= 1'b1;
    wait_clk(10);
    select_n_o <= 1'b0;
    wait_clk(6);
  endtask

  task automatic frame_end();
    wait_clk(6);
    select_n_o <= 1'b1;
    sdio_oe_o  <= 1'b0;
    wait_clk(10);
  endtask
endmodule // spi_host_model

// >>> sim/tb.sv
`timescale 1ns/100ps
module tb;
  logic        core_clk_i, sys_rst_i, sync_i, bus_wr_i, bus_rd_i, float_lvl;
  logic [12:0] bus_addr_i;
  logic [7:0]  bus_wdata_i;
  wire logic [7:0] bus_rdata_o;
  wire logic   sclk, sel_n, host_d, host_oe, sdio_o, sdio_oe_o, div_resync_o, secondary_en_o;
  wire logic   sdio_line;
  int          error_cnt, checked, pulse_cnt;

  // Undriven pin toggles so a stale value never reads as data
  assign sdio_line = sdio_oe_o ? sdio_o : (host_oe ? host_d : float_lvl);
  always @(posedge core_clk_i) float_lvl <= ~sdio_line;
  always @(posedge core_clk_i) if (div_resync_o === 1'b1) pulse_cnt++;

  spi_cfg_port spi_cfg_port_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .sclk_i(sclk), .serial_select_n_i(sel_n), .sdio_i(sdio_line), .sdio_o(sdio_o),
    .sdio_oe_o(sdio_oe_o), .sync_i(sync_i), .bus_addr_i(bus_addr_i),
    .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
    .bus_rdata_o(bus_rdata_o), .div_resync_o(div_resync_o), .secondary_en_o(secondary_en_o));
  spi_host_model spi_host_model_inst (.core_clk_i(core_clk_i), .sdio_i(sdio_line),
    .sclk_o(sclk), .select_n_o(sel_n), .sdio_o(host_d), .sdio_oe_o(host_oe));

  // ==========================================================
  // Compare and bus tasks
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    checked++;
    if (got != exp) begin
      error_cnt++;
      $display("mismatch at %0t: pulses %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic bus_write(input logic [12:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    bus_wr_i    <= 1'b1;
    bus_addr_i  <= a;
    bus_wdata_i <= d;
    @(posedge core_clk_i);
    bus_wr_i <= 1'b0;
  endtask
  task automatic read_chk(input logic [12:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    bus_rd_i   <= 1'b1;
    bus_addr_i <= a;
    @(posedge core_clk_i);
    bus_rd_i <= 1'b0;
    #1 chk_byte(bus_rdata_o, exp);
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic reset_and_idle();
    logic [15:0] g;
    read_chk(13'h0000, 8'h18);
    read_chk(13'h0005, 8'h03);
    bus_write(13'h1008, 8'hff);
    read_chk(13'h1008, 8'h00);
    chk_bit(secondary_en_o, 1'b1);
    // Clocks with select high must not write
    spi_host_model_inst.shift(16'h0008, 16, 1'b0, 1'b0, 1'b0, g);
    spi_host_model_inst.shift(16'h00ff, 8, 1'b0, 1'b0, 1'b0, g);
    read_chk(13'h0008, 8'h00);
  endtask

  task automatic serial_read();
    logic [15:0] g;
    logic [7:0]  exp [3];
    exp = '{8'ha5, 8'h3c, 8'hf0};
    for (int k = 0; k < 3; k++) bus_write(13'h0008 + 13'(k), exp[k]);
    spi_host_model_inst.frame_start();
    spi_host_model_inst.shift({1'b1, 2'b10, 13'h0008}, 16, 1'b0, 1'b0, 1'b1, g);
    chk_bit(sdio_oe_o, 1'b1);
    chk_bit(secondary_en_o, 1'b0);
    for (int k = 0; k < 3; k++) begin
      spi_host_model_inst.shift(16'h0000, 8, 1'b0, 1'b1, 1'b0, g);
      chk_byte(g[7:0], exp[k]);
    end
    spi_host_model_inst.frame_end();
    chk_bit(sdio_oe_o, 1'b0);
    chk_bit(secondary_en_o, 1'b1);
  endtask

  task automatic serial_stream();
    logic [15:0] g;
    spi_host_model_inst.frame_start();
    spi_host_model_inst.shift({1'b0, 2'b11, 13'h000c}, 16, 1'b0, 1'b0, 1'b0, g);
    spi_host_model_inst.shift(16'h005a, 8, 1'b0, 1'b0, 1'b0, g);
    spi_host_model_inst.shift(16'h00c3, 8, 1'b0, 1'b0, 1'b0, g);
    spi_host_model_inst.shift(16'h0096, 8, 1'b0, 1'b0, 1'b0, g);
    spi_host_model_inst.frame_end();
    // Fixed two-byte frame, stalled between its bytes
    spi_host_model_inst.frame_start();
    spi_host_model_inst.shift({1'b0, 2'b01, 13'h000f}, 16, 1'b0, 1'b0, 1'b0, g);
    spi_host_model_inst.shift(16'h0077, 8, 1'b0, 1'b0, 1'b0, g);
    spi_host_model_inst.stall();
    spi_host_model_inst.shift(16'h0088, 8, 1'b0, 1'b0, 1'b0, g);
    spi_host_model_inst.frame_end();
    read_chk(13'h000c, 8'h5a);
    read_chk(13'h000d, 8'hc3);
    read_chk(13'h000e, 8'h96);
    read_chk(13'h000f, 8'h77);
    read_chk(13'h0010, 8'h88);
  endtask

  task automatic lsb_order();
    logic [15:0] g;
    bus_write(13'h0000, 8'h42);
    read_chk(13'h0000, 8'h5a);
    spi_host_model_inst.frame_start();
    spi_host_model_inst.shift({1'b1, 2'b00, 13'h0009}, 16, 1'b1, 1'b0, 1'b1, g);
    spi_host_model_inst.shift(16'h0000, 8, 1'b1, 1'b1, 1'b0, g);
    chk_byte(g[7:0], 8'h3c);
    spi_host_model_inst.frame_end();
    spi_host_model_inst.frame_start();
    spi_host_model_inst.shift({1'b0, 2'b00, 13'h0000}, 16, 1'b1, 1'b0, 1'b0, g);
    spi_host_model_inst.shift(16'h0018, 8, 1'b1, 1'b0, 1'b0, g);
    spi_host_model_inst.frame_end();
    read_chk(13'h0000, 8'h18);
  endtask

  task automatic channel_steer();
    bus_write(13'h0005, 8'h01);
    bus_write(13'h0010, 8'h11);
    bus_write(13'h0005, 8'h02);
    bus_write(13'h0010, 8'h22);
    read_chk(13'h0010, 8'h22);
    bus_write(13'h0005, 8'h03);
    read_chk(13'h0010, 8'h11);
    bus_write(13'h0011, 8'h33);
    bus_write(13'h0005, 8'h02);
    read_chk(13'h0011, 8'h33);
    bus_write(13'h0005, 8'h03);
  endtask

  // Strobe counts split into the high and the low window
  task automatic sync_pulse(input int hi, output int n_hi, output int n_lo);
    int b0;
    int b1;
    @(posedge core_clk_i);
    sync_i <= 1'b1;
    #1 b0 = pulse_cnt;
    repeat (hi) @(posedge core_clk_i);
    sync_i <= 1'b0;
    #1 b1 = pulse_cnt;
    repeat (8) @(posedge core_clk_i);
    #1 n_lo = pulse_cnt - b1;
    n_hi = b1 - b0;
  endtask

  task automatic sync_modes();
    int h;
    int l;
    bus_write(13'h0059, 8'h02);
    bus_write(13'h003a, 8'h02);
    sync_pulse(10, h, l);
    chk_cnt(h + l, 0);
    bus_write(13'h00ff, 8'h01);
    read_chk(13'h00ff, 8'h00);
    sync_pulse(10, h, l);
    chk_cnt(h, 1);
    chk_cnt(l, 0);
    bus_write(13'h0059, 8'h03);
    bus_write(13'h00ff, 8'h01);
    sync_pulse(10, h, l);
    chk_cnt(h, 0);
    chk_cnt(l, 1);
    bus_write(13'h0059, 8'h00);
    bus_write(13'h00ff, 8'h01);
    sync_pulse(5, h, l);
    chk_cnt(h + l, 5);
    bus_write(13'h0059, 8'h02);
    bus_write(13'h003a, 8'h06);
    bus_write(13'h00ff, 8'h01);
    read_chk(13'h003f, 8'h08);
    sync_pulse(10, h, l);
    chk_cnt(h + l, 1);
    sync_pulse(10, h, l);
    chk_cnt(h + l, 0);
    bus_write(13'h003a, 8'h00);
    bus_write(13'h00ff, 8'h01);
    sync_pulse(10, h, l);
    chk_cnt(h + l, 0);
  endtask

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  initial begin
    repeat (60000) @(posedge core_clk_i);
    error_cnt++;
    $display("mismatch at %0t: run timed out", $time);
    wrap_up();
  end

  initial begin
    sys_rst_i   = 1'b1;
    sync_i      = 1'b0;
    bus_wr_i    = 1'b0;
    bus_rd_i    = 1'b0;
    bus_addr_i  = '0;
    bus_wdata_i = '0;
    float_lvl   = 1'b0;
    error_cnt   = 0;
    checked     = 0;
    pulse_cnt   = 0;
    repeat (5) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    reset_and_idle();
    serial_read();
    serial_stream();
    lsb_order();
    channel_steer();
    sync_modes();
    wrap_up();
  end
endmodule // tb
